// File: common/mag_mode_pkg.sv
// Purpose: shared constants and types for the measurement mode control block
// Assumes: clk_sys at 125 MHz, synchronous active-high reset
// Notes: times are kept in their printed units, cycle counts derive from them
package mag_mode_pkg;

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125000000;
  localparam int CLK_PERIOD_PS = 8000;

  // ----------------------------------------------------------------
  // operating-mode field
  // ----------------------------------------------------------------
  localparam int MODE_W = 5;
  localparam logic [4:0] MODE_POWER_DOWN = 5'h00;
  localparam logic [4:0] MODE_SINGLE = 5'h01;
  localparam logic [4:0] MODE_CONT_5HZ = 5'h02;
  localparam logic [4:0] MODE_CONT_10HZ = 5'h04;
  localparam logic [4:0] MODE_CONT_20HZ = 5'h06;
  localparam logic [4:0] MODE_CONT_50HZ = 5'h08;
  localparam logic [4:0] MODE_CONT_100HZ = 5'h0A;
  localparam logic [4:0] MODE_CONT_500HZ = 5'h0C;
  localparam logic [4:0] MODE_CONT_1000HZ = 5'h0E;
  localparam logic [4:0] MODE_CONT_2000HZ = 5'h10;
  localparam logic [4:0] MODE_RESET = 5'h00;

  // ----------------------------------------------------------------
  // other control bits, reset values and set-bit meanings
  // ----------------------------------------------------------------
  localparam logic DRIVE_RESET = 1'b0;
  localparam logic RANGE_RESET = 1'b0;
  localparam logic SELFTEST_RESET = 1'b0;
  localparam logic DRIVE_LOW_POWER = 1'b1;
  localparam logic RANGE_WIDE = 1'b1;

  // ----------------------------------------------------------------
  // scales, in nT per LSB
  // ----------------------------------------------------------------
  localparam logic [11:0] SCALE_HIGH_SENS_NT = 12'h44C;
  localparam logic [11:0] SCALE_WIDE_NT = 12'hC1C;
  localparam int RESULT_W = 16;

  // ----------------------------------------------------------------
  // rates in Hz and period counter width
  // ----------------------------------------------------------------
  localparam int RATE_5_HZ = 5;
  localparam int RATE_10_HZ = 10;
  localparam int RATE_20_HZ = 20;
  localparam int RATE_50_HZ = 50;
  localparam int RATE_100_HZ = 100;
  localparam int RATE_500_HZ = 500;
  localparam int RATE_1000_HZ = 1000;
  localparam int RATE_2000_HZ = 2000;
  localparam int PERIOD_W = 25;

  // ----------------------------------------------------------------
  // measurement duration in ns, typical and maximum
  // ----------------------------------------------------------------
  localparam int TMEAS_LN_TYP_NS = 825000;
  localparam int TMEAS_LN_MAX_NS = 908000;
  localparam int TMEAS_LP_TYP_NS = 265000;
  localparam int TMEAS_LP_MAX_NS = 292000;
  localparam int TMEAS_LN_CYC = TMEAS_LN_TYP_NS * 1000 / CLK_PERIOD_PS;
  localparam int TMEAS_LP_CYC = TMEAS_LP_TYP_NS * 1000 / CLK_PERIOD_PS;
  localparam int MEAS_W = 17;

  // ----------------------------------------------------------------
  // i2c target
  // ----------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR_CONN1 = 7'h10;
  localparam logic [6:0] I2C_ADDR_CONN2 = 7'h11;
  localparam int I2C_FSCL_MAX_KHZ = 1000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_POWER_DOWN = 2'b00,
    ST_MEASURE = 2'b01,
    ST_SAVE = 2'b11
  } meas_state_t;

  typedef struct packed {
    logic [4:0] mode;
    logic drive_select_bit;
    logic range_select_bit;
    logic selftest_enable_bit;
  } ctrl_t;

  typedef struct packed {
    logic wr_mode;
    logic [4:0] mode;
    logic wr_cfg;
    logic drive_select_bit;
    logic range_select_bit;
    logic selftest_enable_bit;
    logic soft_reset_bit;
  } host_wr_t;

  typedef struct packed {
    logic busy;
    logic selftest_active;
    logic [11:0] scale_nt;
    logic periodic;
  } status_t;

endpackage

// File: hw/mag_period_timer.sv
// Purpose: counts the measurement repeat period; the measurement time is counted by the control block
// Assumes: load and enable come from the same clock domain
// Notes: reloads on any mode change so a new rate starts cleanly
`timescale 1ns/1ps
module mag_period_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic restart,
  input wire logic run,
  input wire logic [24:0] period_cycles,
  // event
  output logic tick
);

  typedef struct packed {
    logic [24:0] count;
    logic tick;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart || !run) begin
      // first tick one cycle after start so measurement begins at once
      s_d.count = 25'h0000000;
      s_d.tick = restart && run;
    end else if (s_q.count >= period_cycles - 25'h0000001) begin
      s_d.count = 25'h0000000;
      s_d.tick = 1'b1;
    end else begin
      s_d.count = s_q.count + 25'h0000001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// File: hw/mag_mode_ctrl.sv
// Purpose: operating-mode control and measurement sequencing of the sensor
// Assumes: host writes arrive decoded from the i2c target on clk_sys
// Notes: the analog front end is outside; this block times and steers it
//
// Contract
// - Unused and odd mode codes above one act as power-down.
// - Mode 01h does one measurement, then clears mode to 00h.
// - Mode 02h repeats measurement at 5 Hz.
// - Mode 04h repeats measurement at 10 Hz.
// - Mode 06h repeats measurement at 20 Hz.
// - Mode 08h repeats measurement at 50 Hz.
// - Mode 0Ah repeats measurement at 100 Hz.
// - Mode 0Ch repeats measurement at 500 Hz.
// - Mode 0Eh runs 1000 Hz with low-power drive.
// - Mode 10h runs 2000 Hz with low-power drive.
// - Fastest two modes fall back to 500 Hz under low-noise drive.
// - Periodic mode runs until a new mode is written, then switches.
// - Self-test starts only together with single measurement mode.
// - Soft reset restores all settings and enters power-down.
// - Power-on reset initializes settings, then power-down.
// - Low-noise measurement takes typically 0.825 ms, at most 0.908 ms.
// - Low-power measurement takes typically 0.265 ms, at most 0.292 ms.
// - Range bit 0 selects 1.1 uT per LSB, 16-bit result.
// - Range bit 1 selects 3.1 uT per LSB.
// - Target port runs standard, fast and fast-plus, up to 1000 kHz.
// - Event output is open-drain, active low, released otherwise.
// - Target address is 10h or 11h by pin arrangement.
`timescale 1ns/1ps
module mag_mode_ctrl (
  // clock and reset (power-on detect drives rst)
  input wire logic clk_sys,
  input wire logic rst,
  // decoded host writes
  input wire mag_mode_pkg::host_wr_t host_wr,
  // event request from data-ready logic
  input wire logic event_req,
  // pin arrangement strap, from a pin
  input wire logic conn_sel,
  // settings readback
  output mag_mode_pkg::ctrl_t ctrl,
  output mag_mode_pkg::status_t status,
  output logic [6:0] i2c_target_addr,
  // measurement front-end steering
  output logic meas_start,
  output logic meas_done,
  output logic selftest_drive,
  // open-drain event pin
  output logic event_out_n_o,
  output logic event_out_n_oe
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [24:0] hz_to_cycles(input int hz);
    hz_to_cycles = 25'(mag_mode_pkg::CLK_HZ / hz);
  endfunction

  // repeat period in clk_sys cycles for a mode code; zero means not periodic
  function automatic logic [24:0] mode_period(input logic [4:0] m, input logic lp);
    unique case (m)
      mag_mode_pkg::MODE_CONT_5HZ: mode_period = hz_to_cycles(mag_mode_pkg::RATE_5_HZ);
      mag_mode_pkg::MODE_CONT_10HZ: mode_period = hz_to_cycles(mag_mode_pkg::RATE_10_HZ);
      mag_mode_pkg::MODE_CONT_20HZ: mode_period = hz_to_cycles(mag_mode_pkg::RATE_20_HZ);
      mag_mode_pkg::MODE_CONT_50HZ: mode_period = hz_to_cycles(mag_mode_pkg::RATE_50_HZ);
      mag_mode_pkg::MODE_CONT_100HZ:
        mode_period = hz_to_cycles(mag_mode_pkg::RATE_100_HZ);
      mag_mode_pkg::MODE_CONT_500HZ:
        mode_period = hz_to_cycles(mag_mode_pkg::RATE_500_HZ);
      mag_mode_pkg::MODE_CONT_1000HZ: begin
        mode_period = lp ? hz_to_cycles(mag_mode_pkg::RATE_1000_HZ)
                         : hz_to_cycles(mag_mode_pkg::RATE_500_HZ);
      end
      mag_mode_pkg::MODE_CONT_2000HZ: begin
        mode_period = lp ? hz_to_cycles(mag_mode_pkg::RATE_2000_HZ)
                         : hz_to_cycles(mag_mode_pkg::RATE_500_HZ);
      end
      default: mode_period = 25'h0000000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mag_mode_pkg::ctrl_t ctrl;
    mag_mode_pkg::meas_state_t st;
    logic [16:0] meas_cnt;
    logic lp_meas;
    logic single_pending;
    logic selftest_run;
    logic mode_changed;
    logic meas_start;
    logic meas_done;
    logic conn_s1;
    logic conn_s2;
    logic [6:0] addr;
    logic event_drive;
  } ctrl_state_t;

  localparam mag_mode_pkg::ctrl_t CTRL_INIT = '{
    mode: mag_mode_pkg::MODE_RESET,
    drive_select_bit: mag_mode_pkg::DRIVE_RESET,
    range_select_bit: mag_mode_pkg::RANGE_RESET,
    selftest_enable_bit: mag_mode_pkg::SELFTEST_RESET
  };

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic tick;
  logic [24:0] period_cycles;
  logic periodic;
  logic [16:0] meas_len;

  assign period_cycles = mode_period(s_q.ctrl.mode, s_q.ctrl.drive_select_bit);
  assign periodic = (period_cycles != 25'h0000000);
  // typical figure used; it sits inside the stated maximum
  // drive latched at start: a drive write mid-measurement cannot stretch it
  assign meas_len = s_q.lp_meas
                  ? 17'(mag_mode_pkg::TMEAS_LP_CYC)
                  : 17'(mag_mode_pkg::TMEAS_LN_CYC);

  mag_period_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(s_q.mode_changed),
    .run(periodic),
    .period_cycles(period_cycles),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.meas_start = 1'b0;
    s_d.meas_done = 1'b0;
    s_d.mode_changed = 1'b0;
    s_d.conn_s1 = conn_sel;
    s_d.conn_s2 = s_q.conn_s1;
    s_d.addr = s_q.conn_s2 ? mag_mode_pkg::I2C_ADDR_CONN2
                           : mag_mode_pkg::I2C_ADDR_CONN1;
    s_d.event_drive = event_req;

    if (host_wr.wr_cfg) begin
      s_d.ctrl.drive_select_bit = host_wr.drive_select_bit;
      s_d.ctrl.range_select_bit = host_wr.range_select_bit;
      s_d.ctrl.selftest_enable_bit = host_wr.selftest_enable_bit;
    end

    // measurement sequencing
    unique case (s_q.st)
      mag_mode_pkg::ST_POWER_DOWN,
      mag_mode_pkg::ST_SAVE: begin
        if (s_q.single_pending || (periodic && tick)) begin
          s_d.st = mag_mode_pkg::ST_MEASURE;
          s_d.meas_cnt = 17'h00000;
          s_d.meas_start = 1'b1;
          s_d.lp_meas = s_q.ctrl.drive_select_bit;
          s_d.single_pending = 1'b0;
          // self-test only rides on a single measurement
          s_d.selftest_run = s_q.single_pending && s_q.ctrl.selftest_enable_bit;
        end else if (!periodic) begin
          s_d.st = mag_mode_pkg::ST_POWER_DOWN;
        end
      end
      mag_mode_pkg::ST_MEASURE: begin
        if (s_q.meas_cnt >= meas_len - 17'h00001) begin
          s_d.meas_done = 1'b1;
          s_d.selftest_run = 1'b0;
          if (s_q.ctrl.mode == mag_mode_pkg::MODE_SINGLE) begin
            s_d.ctrl.mode = mag_mode_pkg::MODE_POWER_DOWN;
            s_d.ctrl.selftest_enable_bit = mag_mode_pkg::SELFTEST_RESET;
            s_d.st = mag_mode_pkg::ST_POWER_DOWN;
          end else begin
            s_d.st = periodic ? mag_mode_pkg::ST_SAVE : mag_mode_pkg::ST_POWER_DOWN;
          end
        end else begin
          s_d.meas_cnt = s_q.meas_cnt + 17'h00001;
        end
      end
      default: s_d.st = mag_mode_pkg::ST_POWER_DOWN;
    endcase

    // a host write of the mode wins over auto-clear at measurement end
    if (host_wr.wr_mode) begin
      s_d.ctrl.mode = host_wr.mode;
      s_d.mode_changed = 1'b1;
      s_d.single_pending = (host_wr.mode == mag_mode_pkg::MODE_SINGLE);
    end

    if (host_wr.soft_reset_bit) begin
      s_d = '0;
      s_d.ctrl = CTRL_INIT;
      s_d.st = mag_mode_pkg::ST_POWER_DOWN;
      s_d.conn_s1 = conn_sel;
      s_d.conn_s2 = s_q.conn_s1;
      s_d.addr = s_q.addr;
      // pin keeps mirroring the request; selection logic is outside
      s_d.event_drive = event_req;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_INIT;
      s_q.st <= mag_mode_pkg::ST_POWER_DOWN;
      s_q.addr <= mag_mode_pkg::I2C_ADDR_CONN1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ctrl = s_q.ctrl;
  assign meas_start = s_q.meas_start;
  assign meas_done = s_q.meas_done;
  assign selftest_drive = s_q.selftest_run;
  assign i2c_target_addr = s_q.addr;
  // open drain: only ever drives low
  assign event_out_n_o = 1'b0;
  assign event_out_n_oe = s_q.event_drive;

  always_comb begin
    status.busy = (s_q.st == mag_mode_pkg::ST_MEASURE);
    status.selftest_active = s_q.selftest_run;
    status.scale_nt = s_q.ctrl.range_select_bit
                    ? mag_mode_pkg::SCALE_WIDE_NT
                    : mag_mode_pkg::SCALE_HIGH_SENS_NT;
    status.periodic = periodic;
  end

endmodule

// File: test/host_wr_model.sv
// Purpose: host side model issuing decoded register writes
// Assumes: one write per call, launched at a rising edge
// Notes: holds off while reset is asserted, for at most 64 cycles, as a real host must
`timescale 1ns/1ps
module host_wr_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // decoded host writes
  output mag_mode_pkg::host_wr_t host_wr
);
  initial host_wr = '0;
  // one pulse per write; the mode only changes when the caller asks for it
  task automatic send(input mag_mode_pkg::host_wr_t w);
    @(posedge clk_sys);
    for (int i = 0; i < 64 && rst; i++) @(posedge clk_sys);
    host_wr <= w;
    @(posedge clk_sys);
    host_wr <= '0;
  endtask
endmodule

// File: test/mag_mode_ctrl_props.sv
// Purpose: port-level checks of the measurement mode control block
// Assumes: one clock domain, synchronous active-high reset
// Notes: period check only judges spans with no host write in between
`timescale 1ns/1ps
module mag_mode_ctrl_props (
  // clock, reset and inputs
  input wire logic clk_sys,
  input wire logic rst,
  input wire mag_mode_pkg::host_wr_t host_wr,
  input wire logic event_req,
  input wire logic conn_sel,
  // outputs
  input wire mag_mode_pkg::ctrl_t ctrl,
  input wire mag_mode_pkg::status_t status,
  input wire logic [6:0] i2c_target_addr,
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic selftest_drive,
  input wire logic event_out_n_o,
  input wire logic event_out_n_oe
);
  // ------------------------------
  // helpers
  // ------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  int rate;
  logic pd_w;
  logic sgl_q;
  logic drv_q;
  logic same_q;
  logic [25:0] gap_q;
  logic [16:0] len_q;
  always_comb begin
    case (ctrl.mode)
      5'h02: rate = 5;
      5'h04: rate = 10;
      5'h06: rate = 20;
      5'h08: rate = 50;
      5'h0A: rate = 100;
      5'h0C: rate = 500;
      5'h0E: rate = ctrl.drive_select_bit ? 1000 : 500;
      5'h10: rate = ctrl.drive_select_bit ? 2000 : 500;
      default: rate = 0;
    endcase
  end
  assign pd_w = rate == 0 && ctrl.mode != mag_mode_pkg::MODE_SINGLE;
  // same_q: the previous start ran under the settings still in force
  always_ff @(posedge clk_sys) begin
    gap_q <= meas_start ? 26'h1 : gap_q + 26'h1;
    len_q <= meas_start ? 17'h1 : len_q + 17'h1;
    same_q <= !rst && !(host_wr.wr_mode || host_wr.wr_cfg || host_wr.soft_reset_bit)
      && (meas_start || same_q);
    if (meas_start) begin
      sgl_q <= ctrl.mode == mag_mode_pkg::MODE_SINGLE;
      drv_q <= ctrl.drive_select_bit;
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  property p_pd_quiet;
    pd_w [*4] |-> !meas_start;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("start in power-down");
  property p_single_go;
    (host_wr.wr_mode && host_wr.mode == 5'h01 && !host_wr.soft_reset_bit && pd_w && !status.busy)
      ##1 !(host_wr.wr_mode || host_wr.soft_reset_bit) |-> ctrl.mode == 5'h01 ##1 meas_start;
  endproperty
  a_single_go: assert property (p_single_go) else $error("single did not start");
  property p_single_end;
    meas_done && sgl_q && !host_wr.wr_mode && !$past(host_wr.wr_mode)
      |-> ##[0:1] ctrl.mode == 5'h00;
  endproperty
  a_single_end: assert property (p_single_end) else $error("single did not clear mode");
  property p_selftest;
    selftest_drive |-> (meas_start ? ctrl.mode == 5'h01 : sgl_q);
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test outside single");
  property p_len;
    meas_done |-> len_q <= (drv_q ? 17'(mag_mode_pkg::TMEAS_LP_MAX_NS / 8)
      : 17'(mag_mode_pkg::TMEAS_LN_MAX_NS / 8));
  endproperty
  a_len: assert property (p_len) else $error("measurement too long");
  property p_period;
    meas_start && same_q && rate != 0 |-> gap_q == 26'(mag_mode_pkg::CLK_HZ / rate);
  endproperty
  a_period: assert property (p_period) else $error("bad period");
  property p_soft_reset_bit;
    host_wr.soft_reset_bit |=> ctrl == '0 && !status.busy && !selftest_drive;
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset incomplete");
  property p_por;
    $fell(rst) |-> ctrl == '0 && !meas_start && !event_out_n_oe;
  endproperty
  a_por: assert property (p_por) else $error("reset state wrong");
  property p_scale;
    status.scale_nt == (ctrl.range_select_bit ? 12'hC1C : 12'h44C);
  endproperty
  a_scale: assert property (p_scale) else $error("scale wrong");
  property p_event;
    !event_out_n_o && event_out_n_oe == $past(event_req);
  endproperty
  a_event: assert property (p_event) else $error("event pin wrong");
  property p_addr;
    $stable(conn_sel) [*5] |-> i2c_target_addr == (conn_sel ? 7'h11 : 7'h10);
  endproperty
  a_addr: assert property (p_addr) else $error("target address wrong");
  c_single: cover property (meas_done && sgl_q);
  c_period: cover property (meas_start && same_q && rate != 0);
  c_soft_reset_bit: cover property (host_wr.soft_reset_bit);
endmodule
bind mag_mode_ctrl mag_mode_ctrl_props chk_u (.clk_sys(clk_sys), .rst(rst), .host_wr(host_wr),
  .event_req(event_req), .conn_sel(conn_sel), .ctrl(ctrl), .status(status),
  .i2c_target_addr(i2c_target_addr), .meas_start(meas_start), .meas_done(meas_done),
  .selftest_drive(selftest_drive), .event_out_n_o(event_out_n_o),
  .event_out_n_oe(event_out_n_oe));

// File: test/tb_top.sv
// Purpose: self-checking bench for the measurement mode control block
// Assumes: host writes come from the host model, one pulse per write
// Notes: only the 2000 Hz rate is timed, slower rates would overrun the run
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic event_req = 1'b0;
  logic conn_sel = 1'b0;
  mag_mode_pkg::host_wr_t host_wr;
  mag_mode_pkg::ctrl_t ctrl;
  mag_mode_pkg::status_t status;
  logic [6:0] addr;
  logic meas_start;
  logic meas_done;
  logic selftest_drive;
  logic ev_o;
  logic ev_oe;
  logic b;
  int err_count = 0;
  int checks = 0;
  int n;
  logic [4:0] pd_codes [9] = '{5'h03, 5'h05, 5'h07, 5'h09, 5'h0B, 5'h0D, 5'h0F, 5'h11, 5'h1F};
  always #4 clk_sys = ~clk_sys;
  host_wr_model host_u (.clk_sys(clk_sys), .rst(rst), .host_wr(host_wr));
  mag_mode_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .host_wr(host_wr), .event_req(event_req),
    .conn_sel(conn_sel), .ctrl(ctrl), .status(status), .i2c_target_addr(addr),
    .meas_start(meas_start), .meas_done(meas_done), .selftest_drive(selftest_drive),
    .event_out_n_o(ev_o), .event_out_n_oe(ev_oe));
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic int exp_cycles(input int ns);
    return ns / 8;
  endfunction
  function automatic int exp_period(input int hz);
    return mag_mode_pkg::CLK_HZ / hz;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic mode(input logic [4:0] m);
    host_u.send({1'b1, m, 5'h00});
  endtask
  task automatic cfg(input logic d, input logic r, input logic s);
    host_u.send({6'h00, 1'b1, d, r, s, 1'b0});
  endtask
  // a missed event ends the run rather than hanging it
  task automatic wait_for(input logic on_done, input int lim);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while ((on_done ? meas_done : meas_start) !== 1'b1 && n < lim);
    if ((on_done ? meas_done : meas_start) !== 1'b1) begin
      chk(1'b0, "wait ran out");
      complete_run();
    end
  endtask
  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    void'($urandom(32'h4ADE));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(ctrl === 8'h00 && addr === 7'h10 && ev_oe === 1'b0, "reset state");
    $display("reset test done");
    pd_codes[8] = 5'($urandom_range(31, 17));
    foreach (pd_codes[i]) begin
      b = 1'($urandom);
      cfg(1'($urandom), b, 1'b1);
      mode(pd_codes[i]);
      repeat (6) begin
        @(posedge clk_sys);
        #1;
        chk(meas_start === 1'b0 && selftest_drive === 1'b0, "start in power-down");
      end
      chk(ctrl.mode === pd_codes[i] && status.periodic === 1'b0, "power-down code");
      chk(status.scale_nt === (b ? 12'hC1C : 12'h44C), "scale");
    end
    $display("power-down test done");
    repeat (8) begin
      b = 1'($urandom);
      @(posedge clk_sys);
      event_req <= b;
      @(posedge clk_sys);
      #1;
      chk(ev_oe === b && ev_o === 1'b0, "event pin");
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      conn_sel <= ~s[0];
      repeat (6) @(posedge clk_sys);
      #1;
      chk(addr === (s[0] ? 7'h10 : 7'h11), "address strap");
    end
    $display("pin test done");
    cfg(1'b1, 1'b0, 1'b1);
    mode(5'h01);
    // start pulse stands in the second cycle after the write edge
    @(posedge clk_sys);
    #1;
    chk(meas_start === 1'b1 && selftest_drive === 1'b1, "single start");
    chk(status.selftest_active === 1'b1 && status.busy === 1'b1, "single busy");
    wait_for(1'b1, 40000);
    chk(n <= exp_cycles(292000), "low-power length");
    @(posedge clk_sys);
    #1;
    chk(ctrl.mode === 5'h00 && selftest_drive === 1'b0, "single return");
    $display("single test done");
    cfg(1'b1, 1'b0, 1'b0);
    mode(5'h10);
    wait_for(1'b0, 10);
    chk(status.periodic === 1'b1 && selftest_drive === 1'b0, "periodic flag");
    wait_for(1'b0, 70000);
    chk(n == exp_period(2000), "2000 Hz period");
    mode(5'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(ctrl.mode === 5'h00 && status.periodic === 1'b0, "periodic stop");
    $display("periodic test done");
    cfg(1'b1, 1'b1, 1'b1);
    mode(5'h0A);
    host_u.send(11'h001);
    @(posedge clk_sys);
    #1;
    chk(ctrl === 8'h00 && status.busy === 1'b0, "soft reset");
    $display("soft reset test done");
    // every periodic code starts at once; soft reset aborts the run between codes
    for (int m = 2; m <= 16; m += 2) begin
      host_u.send(11'h001);
      mode(5'(m));
      wait_for(1'b0, 10);
      chk(status.periodic === 1'b1, "rate code");
    end
    $display("rate code test done");
    complete_run();
  end
endmodule
